// [design/wdtc_top.v]
// Purpose: Watchdog timeout control with status, force and keyboard-line force
// Assumes: AHB-Lite slave, single word transfers, 200 MHz clk_sys_in
// Notes:   Counter decrements once per unit; unit length from tick register
// What this block does
// - Bit 0 status: 1 timed out, 0 counting
// - Writing force bit raises timeout event at once
// - Force bit write-only, clears by itself
// - Enabled keyboard line rising edge forces timeout
// - Disabled keyboard line is fully ignored
// - Software force works with keyboard path enabled
// - Self-clearing edge pulse ORed with software force
// - Eight-bit timeout count, zero disables
`timescale 1ns/100ps
`default_nettype none
`include "wdtc_map.vh"
module wdtc_top
#(
  parameter [31:0] TICKS_PER_SEC = 32'd200000000
)
(
  input  wire        clk_sys_in,
  input  wire        resetn_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output reg  [31:0] hrdata_out,
  input  wire        kbc_force_line_in,
  output wire        wdt_timeout_out,
  output wire        irq_out
);
  function [31:0] byte_addr;
    input [7:0] idx;
    begin
      byte_addr = {22'd0, idx, 2'b00};
    end
  endfunction

  reg        wr_pend_r;
  reg [31:0] addr_r;
  reg        ctrl_status_r;
  reg        ctrl_kbc_en_r;
  reg        units_sec_r;
  reg [7:0]  value_r;
  reg [7:0]  count_r;
  reg [31:0] tick_r;
  reg [31:0] tick_cnt_r;
  reg [7:0]  sec_cnt_r;
  reg [`WDTC_IRQ_W-1:0] irq_stat_r;
  reg [`WDTC_IRQ_W-1:0] irq_en_r;
  reg        timeout_evt_r;

  wire kbc_rise;
  wire access  = hsel_in & hready_in & htrans_in[1];
  wire wr_ctrl = wr_pend_r & (addr_r == byte_addr(`WDTC_IDX_CTRL));
  wire sw_force = wr_ctrl & hwdata_in[`WDTC_BIT_FORCE];
  wire kbc_force = kbc_rise & ctrl_kbc_en_r;
  wire unit_tick = (tick_cnt_r == 32'd0) & (~units_sec_r ? (sec_cnt_r == 8'd0) : 1'b1);
  wire expire  = (value_r != `WDTC_VALUE_OFF) & ~ctrl_status_r & unit_tick & (count_r == 8'd1);
  wire evt     = sw_force | kbc_force | expire;

  wdtc_edge u_edge
  (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .level_in   (kbc_force_line_in),
    .rise_out   (kbc_rise)
  );

  assign hreadyout_out   = 1'b1;
  assign hresp_out       = 1'b0;
  assign wdt_timeout_out = timeout_evt_r;
  assign irq_out         = |(irq_stat_r & irq_en_r);

  // Zero-wait slave: address captured, write data used in next cycle
  always @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= access & hwrite_in;
      if (access)
        addr_r <= {haddr_in[31:2], 2'b00};
    end
  end

  always @(posedge clk_sys_in)
  begin
    if (!resetn_in)
      hrdata_out <= 32'h0000_0000;
    else if (access & ~hwrite_in)
    begin
      case ({haddr_in[31:2], 2'b00})
        byte_addr(`WDTC_IDX_CTRL):     hrdata_out <= {28'd0, ctrl_kbc_en_r, 2'b00, ctrl_status_r};
        byte_addr(`WDTC_IDX_VALUE):    hrdata_out <= {24'd0, value_r};
        byte_addr(`WDTC_IDX_UNITS):    hrdata_out <= {24'd0, units_sec_r, 7'd0};
        byte_addr(`WDTC_IDX_IRQ_STAT): hrdata_out <= {30'd0, irq_stat_r};
        byte_addr(`WDTC_IDX_IRQ_EN):   hrdata_out <= {30'd0, irq_en_r};
        byte_addr(`WDTC_IDX_TICK):     hrdata_out <= tick_r;
        default:                       hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Registers; hardware set of status wins over software write of zero
  always @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      ctrl_status_r <= 1'b0;
      ctrl_kbc_en_r <= 1'b0;
      units_sec_r   <= 1'b0;
      value_r       <= `WDTC_VALUE_RESET;
      tick_r        <= `WDTC_TICK_RESET;
      irq_en_r      <= {`WDTC_IRQ_W{1'b0}};
      irq_stat_r    <= {`WDTC_IRQ_W{1'b0}};
      timeout_evt_r <= 1'b0;
    end
    else
    begin
      timeout_evt_r <= evt;
      if (evt)
        ctrl_status_r <= 1'b1;
      else if (wr_ctrl)
        ctrl_status_r <= hwdata_in[`WDTC_BIT_STATUS];
      if (wr_ctrl)
        ctrl_kbc_en_r <= hwdata_in[`WDTC_BIT_KBC_EN];
      if (wr_pend_r & (addr_r == byte_addr(`WDTC_IDX_VALUE)))
        value_r <= hwdata_in[7:0];
      if (wr_pend_r & (addr_r == byte_addr(`WDTC_IDX_UNITS)))
        units_sec_r <= hwdata_in[`WDTC_BIT_UNITS];
      if (wr_pend_r & (addr_r == byte_addr(`WDTC_IDX_TICK)))
        tick_r <= hwdata_in;
      if (wr_pend_r & (addr_r == byte_addr(`WDTC_IDX_IRQ_EN)))
        irq_en_r <= hwdata_in[`WDTC_IRQ_W-1:0];
      irq_stat_r <= (irq_stat_r &
                     ~((wr_pend_r & (addr_r == byte_addr(`WDTC_IDX_IRQ_CLR))) ?
                       hwdata_in[`WDTC_IRQ_W-1:0] : {`WDTC_IRQ_W{1'b0}}))
                    | {kbc_force, evt};
    end
  end

  // Unit timebase and countdown; reloaded while counting is idle
  always @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      tick_cnt_r <= 32'h0000_0000;
      sec_cnt_r  <= 8'd0;
      count_r    <= `WDTC_VALUE_RESET;
    end
    else
    begin
      tick_cnt_r <= (tick_cnt_r == 32'd0) ? tick_r - 32'd1 : tick_cnt_r - 32'd1;
      if (tick_cnt_r == 32'd0)
        sec_cnt_r <= (sec_cnt_r == 8'd0) ? `WDTC_SEC_PER_MIN - 8'd1 : sec_cnt_r - 8'd1;
      // An empty count must reload too, else a fresh value never starts
      if ((value_r == `WDTC_VALUE_OFF) | ctrl_status_r | (count_r == 8'd0))
        count_r <= value_r;
      else if (unit_tick & (count_r != 8'd0))
        count_r <= count_r - 8'd1;
    end
  end
endmodule
`default_nettype wire

// [design/wdtc_map.vh]
// Purpose: Register map and constants of the watchdog timeout control block
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes:   Offsets are word indices; byte address is index times 4, so 0xf4 maps to 0x3d0
`ifndef WDTC_MAP_VH
`define WDTC_MAP_VH

`define WDTC_IDX_CTRL       8'hf4
`define WDTC_IDX_VALUE      8'hf2
`define WDTC_IDX_UNITS      8'hf1
`define WDTC_IDX_IRQ_STAT   8'hf8
`define WDTC_IDX_IRQ_EN     8'hf9
`define WDTC_IDX_IRQ_CLR    8'hfa
`define WDTC_IDX_TICK       8'hfb

`define WDTC_BIT_STATUS     0
`define WDTC_BIT_FORCE      2
`define WDTC_BIT_KBC_EN     3
`define WDTC_BIT_UNITS      7
`define WDTC_CTRL_RW_MASK   8'h09
`define WDTC_CTRL_RESET     8'h00
`define WDTC_VALUE_RESET    8'h00
`define WDTC_VALUE_OFF      8'h00

`define WDTC_IRQ_W          2
`define WDTC_IRQ_TIMEOUT    0
`define WDTC_IRQ_KBC        1

`define WDTC_HTRANS_NONSEQ  2'b10
`define WDTC_HTRANS_SEQ     2'b11

`define WDTC_TICK_RESET     32'h0000_00c8
`define WDTC_SEC_PER_MIN    8'h3c

`endif

// [design/wdtc_edge.v]
// Purpose: Synchronise a level and give one pulse per rising edge
// Assumes: Input may be asynchronous to clk_sys_in
// Notes:   Pulse self-clears after one cycle however long the line stays high
`timescale 1ns/100ps
`default_nettype none
module wdtc_edge
(
  input  wire clk_sys_in,
  input  wire resetn_in,
  input  wire level_in,
  output wire rise_out
);
  reg sync1_r;
  reg sync2_r;
  reg prev_r;

  always @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= level_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise_out = sync2_r & ~prev_r;
endmodule
`default_nettype wire

// [sim/wdtc_chk.sv]
// Purpose: Port checks of wdtc_top
// Assumes: Zero wait states, write data one cycle after address
// Notes:   Enable bit shadowed from bus writes
`timescale 1ns/100ps
`default_nettype none
module wdtc_chk
(
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic        kbc_force_line_in,
  input wire logic        wdt_timeout_out
);
  logic wa_r;
  logic en_r;
  wire  ap = hsel_in && htrans_in[1];
  wire  wc = ap && hwrite_in && haddr_in == 32'h3d0;
  always @(posedge clk_sys_in)
  begin
    wa_r <= wc;
    en_r <= resetn_in && (wa_r ? hwdata_in[3] : en_r);
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  property p_rdy; hreadyout_out; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_ok; !hresp_out; endproperty
  a_ok: assert property (p_ok) else $error("error response");
  property p_one; wdt_timeout_out |=> !wdt_timeout_out [*2]; endproperty
  a_one: assert property (p_one) else $error("long pulse");
  property p_rd; ap && !hwrite_in && haddr_in == 32'h3d0 |=> hrdata_out[31:4] == 0 && hrdata_out[2:1] == 0; endproperty
  a_rd: assert property (p_rd) else $error("control read");
  property p_um; ap && !hwrite_in && haddr_in == 32'h3f0 |=> hrdata_out == 0; endproperty
  a_um: assert property (p_um) else $error("unmapped read");
  property p_frc; wc ##1 hwdata_in[2] |-> ##[1:4] wdt_timeout_out; endproperty
  a_frc: assert property (p_frc) else $error("no forced pulse");
  property p_ken; $rose(kbc_force_line_in) && en_r |-> ##[1:6] wdt_timeout_out; endproperty
  a_ken: assert property (p_ken) else $error("no line pulse");
  property p_kdis; $rose(kbc_force_line_in) && !en_r |-> !wdt_timeout_out [*8]; endproperty
  a_kdis: assert property (p_kdis) else $error("line not ignored");
  c_to: cover property (wdt_timeout_out);
  c_wr: cover property (wc);
  c_ken: cover property ($rose(kbc_force_line_in) && en_r);
endmodule
bind wdtc_top wdtc_chk i_wdtc_chk (.clk_sys_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
  .hwdata_in, .hreadyout_out, .hresp_out, .hrdata_out, .kbc_force_line_in, .wdt_timeout_out);
`default_nettype wire

// [sim/wdtc_kbc_model.sv]
// Purpose: Keyboard controller force line
// Assumes: One go pulse starts a high period
// Notes:   Held past 1us so only the edge may count
`timescale 1ns/100ps
`default_nettype none
module wdtc_kbc_model
(
  input  wire logic clk_sys_in,
  input  wire logic go_in,
  output var  logic line_out
);
  int cnt_r = 0;
  initial line_out = 1'b0;
  always @(posedge clk_sys_in)
  begin
    cnt_r <= go_in ? 220 : (cnt_r > 0 ? cnt_r - 1 : 0);
    line_out <= go_in || cnt_r > 1;
  end
endmodule
`default_nettype wire

// [sim/watchdog_timeout_control_tb.sv]
// Purpose: Self-checking bench of wdtc_top
// Assumes: Zero wait state slave
// Notes:   Reads queue their expectations for the monitor
`timescale 1ns/100ps
`default_nettype none
module watchdog_timeout_control_tb;
  logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, go = 0, rdp = 0;
  logic        kbc, rdy, resp, tmo, irq;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [15:0] rnd = 16'd15199;
  logic [31:0] q[$];
  int          num_errors = 0, n_compared = 0, n_to = 0, e_to = 0, cyc = 0;
  wdtc_top i_wdtc_top (.clk_sys_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(rdy),
    .hreadyout_out(rdy), .hresp_out(resp), .hrdata_out(hrdata), .kbc_force_line_in(kbc),
    .wdt_timeout_out(tmo), .irq_out(irq));
  wdtc_kbc_model i_wdtc_kbc_model (.clk_sys_in(clk), .go_in(go), .line_out(kbc));
  initial forever #2.5 clk = ~clk;
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task xf(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    xf(0, a, 0);
  endtask
  task ck_irq(input logic e);
    @(negedge clk);
    chk(irq, e);
    @(posedge clk);
  endtask
  task kick(input int n);
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (n) @(posedge clk);
  endtask
  task tally_and_finish;
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (rdp && rdy)
      chk(hrdata, q.pop_front());
    if (rdy)
      rdp <= hsel && htrans[1] && !hwrite;
    if (tmo === 1'b1)
      n_to++;
    if (cyc == 3000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(32'h3d0, 0);
    rd(32'h3f0, 0);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      xf(1, 32'h3d0, {28'h0, rnd[3], 2'b0, rnd[0]});
      rd(32'h3d0, {28'h0, rnd[3], 2'b0, rnd[0]});
    end
    xf(1, 32'h3d0, 0);
    xf(1, 32'h3e4, 3);
    xf(1, 32'h3d0, 4);
    e_to++;
    repeat (3) @(posedge clk);
    rd(32'h3d0, 1);
    rd(32'h3e0, 1);
    ck_irq(1);
    xf(1, 32'h3e4, 0);
    ck_irq(0);
    xf(1, 32'h3e4, 3);
    ck_irq(1);
    xf(1, 32'h3e8, 3);
    ck_irq(0);
    xf(1, 32'h3d0, 8);
    kick(8);
    e_to++;
    rd(32'h3d0, 9);
    rd(32'h3e0, 3);
    xf(1, 32'h3d0, 12);
    e_to++;
    repeat (250) @(posedge clk);
    rd(32'h3d0, 9);
    xf(1, 32'h3d0, 0);
    kick(250);
    rd(32'h3d0, 0);
    xf(1, 32'h3c4, 32'h80);
    xf(1, 32'h3c8, 1);
    e_to++;
    repeat (250) @(posedge clk);
    rd(32'h3c8, 1);
    rd(32'h3d0, 1);
    xf(1, 32'h3c8, 0);
    chk(n_to, e_to);
    tally_and_finish;
  end
endmodule
`default_nettype wire
